// ### dv/daq_board_control_registers_tb.sv
// self-checking bench for the board control register bank
// assumes the host model makes every bus cycle
`timescale 1ns/1ns
module daq_board_control_registers_tb;
	import daq_ctrl_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, convPause, twosComplement, irqReq, secondDacLoad, firstDacUpdate;
	logic dacAutoMode, diffMode, scanUnderIn, scanAtEnd, fifoHalfFull, fifoFull;
	logic timerWrStb, timerRdStb;
	logic [1:0] htrans, timerSel;
	logic [2:0] hsize;
	logic [3:0] channelInUse;
	logic [7:0] timerWdata, timerRdata, calPot0, calPot1, calPot2, calPot3;
	logic [15:0] secondDacWord, dioOut, dioOe, extPins, dioIn;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [7:0] pv [4] = '{8'h4f, 8'ha6, 8'h01, 8'hfe};
	int errors = 0;
	int comparisons = 0;
	// pins show the bank's driver where enabled, else the outside level
	assign dioIn = (dioOe & dioOut) | (~dioOe & extPins);
	always #2 mclk = ~mclk;
	daq_host_model host (.hready(hreadyout), .*);
	daq_board_control_registers dut (.hready(hreadyout), .*);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [5:0] idx, input logic [15:0] d);
		host.xfer(1'b1, idx, d, q);
	endtask
	task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
		host.xfer(1'b0, idx, 16'h0, q);
		chk(q, exp);
	endtask
	task automatic t_start();
		#1 chk({irqReq, twosComplement, hresp, dioOe}, 19'h0);
		rd(6'h3f, 32'h0); // unmapped place reads zero
		channelInUse <= 4'hb;
		scanUnderIn <= 1'b1;
		rd(IDX_CHANNEL_READBACK, 32'h3b);
		{channelInUse, diffMode, scanUnderIn, scanAtEnd} <= 7'h6d;
		timerRdata <= 8'h77;
		host.xfer(1'b0, IDX_CHANNEL_READBACK, 16'h0, q);
		chk(q, 32'h05);
		wr(IDX_TIMER_FIRST + 6'h1, 16'h5a);
		#1 chk({timerWrStb, timerSel, timerWdata}, 11'h55a);
		rd(IDX_TIMER_LAST, 32'h77);
		$display("t_start end");
	endtask
	// every select code with its own value, then all four read back
	task automatic t_cal();
		for (int s = 0; s < 4; s++)
			host.cal_load(2'(s), pv[s]);
		#1 chk({calPot3, calPot2, calPot1, calPot0}, {pv[3], pv[2], pv[1], pv[0]});
		for (int s = 0; s < 4; s++)
			rd(IDX_CAL_VALUE + 6'(s), {24'h0, pv[s]});
		$display("t_cal end");
	endtask
	task automatic t_ctrl();
		@(posedge mclk);
		{fifoHalfFull, fifoFull} <= 2'b11;
		wr(IDX_IRQ_ENABLE, 16'h10);
		@(posedge mclk);
		#1 chk({irqReq, convPause}, 2'b11);
		wr(IDX_IRQ_ENABLE, 16'h0);
		@(posedge mclk);
		#1 chk(irqReq, 1'b0);
		wr(IDX_FORMAT_SELECT, 16'h1);
		#1 chk(twosComplement, 1'b1);
		wr(IDX_FORMAT_SELECT, 16'h0);
		#1 chk(twosComplement, 1'b0);
		wr(IDX_DAC_MODE, 16'h0);
		wr(IDX_FIRST_DAC, 16'h1234);
		#1 chk(firstDacUpdate, 1'b1);
		wr(IDX_SECOND_DAC, 16'hbeef);
		repeat (2) @(posedge mclk);
		#1 chk({dacAutoMode, secondDacWord}, 17'h0beef);
		wr(IDX_DAC_MODE, 16'h1);
		#1 chk(dacAutoMode, 1'b1);
		wr(IDX_FIRST_DAC, 16'h5678);
		#1 chk(firstDacUpdate, 1'b0);
		$display("t_ctrl end");
	endtask
	// pins pass a two-stage synchroniser, hence the waits
	task automatic t_dio();
		@(posedge mclk);
		extPins <= 16'h5aa5;
		repeat (3) @(posedge mclk);
		rd(IDX_DIO_LOW, 32'ha5);
		wr(IDX_DIO_LOW, 16'h3c);
		#1 chk({dioOe, dioOut[7:0]}, 24'h00ff3c);
		rd(IDX_DIO_LOW, 32'h3c);
		rd(IDX_DIO_HIGH, 32'h5a);
		wr(IDX_DIO_HIGH, 16'hc3);
		#1 chk({dioOe, dioOut}, 32'hffffc33c);
		wr(IDX_DIO_RESET, 16'h0);
		#1 chk(dioOe, 16'h0);
		repeat (3) @(posedge mclk);
		rd(IDX_DIO_LOW, 32'ha5);
		$display("t_dio end");
	endtask
	// inputs quiet at time zero, reset held six cycles
	initial begin
		{channelInUse, diffMode, scanUnderIn, scanAtEnd, fifoHalfFull, fifoFull, timerRdata, extPins} = '0;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		t_start();
		t_cal();
		t_ctrl();
		t_dio();
		final_report();
	end
	// the sequence needs under two thousand cycles
	initial begin
		#40000;
		errors++;
		final_report();
	end
endmodule // daq_board_control_registers_tb

// ### dv/daq_ctrl_properties.sv
// port checks for the board control register bank
// assumes hready is looped back from hreadyout
`timescale 1ns/1ns
module daq_ctrl_properties (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic fifoHalfFull,
	input wire logic fifoFull,
	input wire logic convPause,
	input wire logic twosComplement,
	input wire logic irqReq,
	input wire logic secondDacLoad,
	input wire logic firstDacUpdate,
	input wire logic dacAutoMode,
	input wire logic timerRdStb,
	input wire logic [15:0] dioOut,
	input wire logic [15:0] dioOe
);
	import daq_ctrl_pkg::*;
	logic wrAcc;
	logic [5:0] idx;
	// write address phase taken; its data follows a cycle later
	assign wrAcc = hsel && hready && htrans[1] && hwrite;
	assign idx = haddr[7:2];
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_irq_half: assert property (irqReq |-> $past(fifoHalfFull)) else $error("stray irq");
	a_irq_off: assert property (wrAcc && idx == IDX_IRQ_ENABLE ##1 hwdata[7:0] == IRQ_OFF_VALUE
		|=> ##1 !irqReq [*3]) else $error("irq after disable");
	a_pause_full: assert property (fifoFull |=> convPause) else $error("no pause");
	a_format_sel: assert property (wrAcc && idx == IDX_FORMAT_SELECT ##1 hwdata[7:1] == 7'h0
		|=> twosComplement == $past(hwdata[0])) else $error("format not taken");
	a_mode_sel: assert property (wrAcc && idx == IDX_DAC_MODE ##1 hwdata[7:1] == 7'h0
		|=> dacAutoMode == $past(hwdata[0])) else $error("mode not taken");
	a_dac_two_load: assert property (wrAcc && idx == IDX_SECOND_DAC |-> ##[1:3] secondDacLoad)
		else $error("no dac load");
	a_dac_one_update: assert property (wrAcc && idx == IDX_FIRST_DAC && !dacAutoMode |-> ##[1:3] firstDacUpdate)
		else $error("no update");
	a_dio_drive: assert property (wrAcc && idx == IDX_DIO_LOW |=> ##1 dioOe[7:0] == 8'hff
		&& dioOut[7:0] == $past(hwdata[7:0])) else $error("group not driven");
	a_dio_release: assert property (wrAcc && idx == IDX_DIO_RESET |=> ##1 dioOe == 16'h0)
		else $error("groups still driven");
	a_timer_read: assert property (hsel && hready && htrans[1] && !hwrite && idx >= IDX_TIMER_FIRST
		&& idx <= IDX_TIMER_LAST |=> ##1 timerRdStb) else $error("no timer read strobe");
endmodule // daq_ctrl_properties

bind daq_board_control_registers daq_ctrl_properties props (
	.mclk(mclk),
	.rst_n(rst_n),
	.hsel(hsel),
	.haddr(haddr),
	.htrans(htrans),
	.hwrite(hwrite),
	.hready(hready),
	.hwdata(hwdata),
	.fifoHalfFull(fifoHalfFull),
	.fifoFull(fifoFull),
	.convPause(convPause),
	.twosComplement(twosComplement),
	.irqReq(irqReq),
	.secondDacLoad(secondDacLoad),
	.firstDacUpdate(firstDacUpdate),
	.dacAutoMode(dacAutoMode),
	.timerRdStb(timerRdStb),
	.dioOut(dioOut),
	.dioOe(dioOe)
);

// ### dv/daq_host_model.sv
// host processor model: single-word ahb-lite transfers to the bank
// assumes hready is the slave's hreadyout
`timescale 1ns/1ns
module daq_host_model (
	input wire logic mclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel = 1'b0,
	output logic [31:0] haddr = 32'h0,
	output logic [1:0] htrans = 2'b00,
	output logic hwrite = 1'b0,
	output logic [2:0] hsize = 3'b010,
	output logic [31:0] hwdata = 32'h0
);
	import daq_ctrl_pkg::*;
	// address held until hready, then data until hready; released lines are inverted so stale values never match
	task automatic xfer(input logic wr, input logic [5:0] idx, input logic [15:0] d, output logic [31:0] rd);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h0, idx, 2'b00};
		do @(posedge mclk); while (!hready);
		hsel <= 1'b0;
		htrans <= 2'b00;
		haddr <= ~haddr;
		hwdata <= wr ? {16'h0, d} : ~hwdata;
		do @(posedge mclk); while (!hready);
		rd = hrdata;
		hwdata <= ~hwdata;
	endtask
	// select then value, msb first, then the closing write
	task automatic cal_load(input logic [1:0] sel, input logic [7:0] val);
		logic [9:0] bits;
		logic [31:0] q;
		bits = {sel, val};
		for (int i = 9; i >= 0; i--) begin
			xfer(1'b1, IDX_CAL_SERIAL, {8'h0, bits[i], 7'h01}, q);
		end
		xfer(1'b1, IDX_CAL_SERIAL, 16'h0001, q);
	endtask
endmodule // daq_host_model

// ### src/ahb_front.sv
// ahb-lite slave front end: captures address phase, emits one strobe
// assumes single whole-word transfers; always OKAY, zero wait states on writes, one on reads
`timescale 1ns/1ns
module ahb_front (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	ahb_req_if.front req
);
	logic wrPend_ff;
	logic rdPend_ff;
	logic [5:0] idx_ff;
	wire take = hsel & hready & htrans[1];
	// address phase registered, strobes fire in the data phase
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wrPend_ff <= 1'b0;
			rdPend_ff <= 1'b0;
			idx_ff <= 6'h00;
		end else begin
			wrPend_ff <= take & hwrite;
			rdPend_ff <= take & ~hwrite;
			if (take) begin
				idx_ff <= haddr[7:2];
			end
		end
	end
	assign req.wrStb = wrPend_ff;
	assign req.rdStb = rdPend_ff;
	assign req.idx = idx_ff;
	assign req.wdata = hwdata;
endmodule // ahb_front

// ### src/ahb_req_if.sv
// bundle carrying one decoded register access from the slave front end
// assumes a single clock shared by both ends
`timescale 1ns/1ns
interface ahb_req_if;
	logic wrStb;
	logic rdStb;
	logic [5:0] idx;
	logic [31:0] wdata;
	modport front (output wrStb, output rdStb, output idx, output wdata);
	modport bank (input wrStb, input rdStb, input idx, input wdata);
endinterface

// ### src/daq_board_control_registers.sv
// board control register bank behind an ahb-lite slave
// assumes converter, fifo and scan logic drive status inputs on mclk
// Behaviour
// - channel readback shows channel in use
// - top channel bit ignored in differential mode
// - scan flag low before end, high after
// - end flag zero at scan end
// - four 8-bit calibration pots, 2-bit select
// - eleven writes: address, value, termination
// - serial bit 7, clock bit 0
// - irq at fifo half full when enabled
// - 10 enables interrupts, 00 disables
// - full fifo pauses conversions
// - binary offset default, 01 twos complement
// - second dac word register like first
// - simultaneous mode updates from first dac writes
// - low group input reads pins 0-7
// - high group input reads pins 8-15
// - group write sets output, drives value
// - output group reads last written value
// - write to 19 returns groups to input
// - 01 automatic dac, 00 simultaneous
// - counter-timer at offsets 14 to 17
`timescale 1ns/1ns
module daq_board_control_registers (
	input wire logic mclk,
	input wire logic rst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// converter side status
	input wire logic [3:0] channelInUse,
	input wire logic diffMode,
	input wire logic scanUnderIn,
	input wire logic scanAtEnd,
	input wire logic fifoHalfFull,
	input wire logic fifoFull,
	output logic convPause,
	output logic twosComplement,
	output logic irqReq,
	// dac side
	output logic [15:0] secondDacWord,
	output logic secondDacLoad,
	output logic firstDacUpdate,
	output logic dacAutoMode,
	// counter-timer window
	output logic timerWrStb,
	output logic timerRdStb,
	output logic [1:0] timerSel,
	output logic [7:0] timerWdata,
	input wire logic [7:0] timerRdata,
	// calibration pots
	output logic [7:0] calPot0,
	output logic [7:0] calPot1,
	output logic [7:0] calPot2,
	output logic [7:0] calPot3,
	// digital io pins
	input wire logic [15:0] dioIn,
	output logic [15:0] dioOut,
	output logic [15:0] dioOe
);
	import daq_ctrl_pkg::*;

	ahb_req_if req ();

	ahb_front u_front (
		.mclk(mclk),
		.rst_n(rst_n),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hready(hready),
		.hwdata(hwdata),
		.req(req.front)
	);

	logic [15:0] dioSync1_ff;
	logic [15:0] dioSync2_ff;
	logic irqEn_ff;
	logic twos_ff;
	logic autoMode_ff;
	logic outLow_ff;
	logic outHigh_ff;
	logic [15:0] dioLatch_ff;
	logic [15:0] dac2_ff;
	logic dac2Load_ff;
	logic dac1Upd_ff;
	logic irq_ff;
	logic pause_ff;
	logic [31:0] rdata_ff;
	logic tWr_ff;
	logic tRd_ff;
	logic [1:0] tSel_ff;
	logic [7:0] tData_ff;
	cal_state_t calState_ff;
	logic [3:0] calCount_ff;
	logic [1:0] calSel_ff;
	logic [7:0] calShift_ff;
	logic [7:0] calPot_ff [4];
	logic hresp_ff;
	// loader next values, worked out beside the registers to keep the clocked block short
	cal_state_t nxt_calState;
	logic [3:0] nxt_calCount;
	logic [1:0] nxt_calSel;
	logic [7:0] nxt_calShift;
	logic calCommit;

	// write decode from the registered address phase
	wire [7:0] wByte = req.wdata[7:0];
	wire wrFormat = req.wrStb & (req.idx == IDX_FORMAT_SELECT);
	wire wrIrq = req.wrStb & (req.idx == IDX_IRQ_ENABLE);
	wire wrCal = req.wrStb & (req.idx == IDX_CAL_SERIAL);
	wire wrDac2 = req.wrStb & (req.idx == IDX_SECOND_DAC);
	wire wrDac1 = req.wrStb & (req.idx == IDX_FIRST_DAC);
	wire wrLow = req.wrStb & (req.idx == IDX_DIO_LOW);
	wire wrHigh = req.wrStb & (req.idx == IDX_DIO_HIGH);
	wire wrMode = req.wrStb & (req.idx == IDX_DAC_MODE);
	wire wrDioRst = req.wrStb & (req.idx == IDX_DIO_RESET);
	wire inTimer = (req.idx >= IDX_TIMER_FIRST) & (req.idx <= IDX_TIMER_LAST);
	wire calClk = wByte[CAL_CLOCK_BIT];
	wire calBit = wByte[CAL_DATA_BIT];
	wire calStep = wrCal & calClk;
	// only the documented command bytes act; any other byte leaves the setting alone
	wire irqOnCmd = wrIrq & (wByte == IRQ_ON_VALUE);
	wire irqOffCmd = wrIrq & (wByte == IRQ_OFF_VALUE);
	wire twosOnCmd = wrFormat & (wByte == MODE_ONE_VALUE);
	wire twosOffCmd = wrFormat & (wByte == MODE_ZERO_VALUE);
	wire autoOnCmd = wrMode & (wByte == MODE_ONE_VALUE);
	wire autoOffCmd = wrMode & (wByte == MODE_ZERO_VALUE);

	// top channel bit means nothing in differential mode, so read it as zero
	wire [3:0] chanShown = {channelInUse[3] & ~diffMode, channelInUse[2:0]};
	wire [7:0] chanByte = {2'b00, scanUnderIn, ~scanAtEnd, chanShown};
	// input groups read synced pins, output groups their latch
	wire [7:0] lowByte = outLow_ff ? dioLatch_ff[7:0] : dioSync2_ff[7:0];
	wire [7:0] highByte = outHigh_ff ? dioLatch_ff[15:8] : dioSync2_ff[15:8];
	wire [1:0] potIdx = req.idx[1:0];
	wire rdIsChan = req.idx == IDX_CHANNEL_READBACK;
	wire rdIsLow = req.idx == IDX_DIO_LOW;
	wire rdIsHigh = req.idx == IDX_DIO_HIGH;
	wire rdIsPot = req.idx[5:2] == IDX_CAL_VALUE[5:2];
	wire [7:0] rdSel = rdIsChan ? chanByte :
		rdIsLow ? lowByte :
		rdIsHigh ? highByte :
		rdIsPot ? calPot_ff[potIdx] :
		inTimer ? timerRdata : 8'h00;

	// pin synchroniser; only the second stage is read
	always_ff @(posedge mclk) begin
		dioSync1_ff <= dioIn;
		dioSync2_ff <= dioSync1_ff;
	end

	// mode and enable registers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			irqEn_ff <= 1'b0;
			twos_ff <= 1'b0;
			autoMode_ff <= 1'b0;
		end else begin
			if (irqOnCmd) begin
				irqEn_ff <= 1'b1;
			end else if (irqOffCmd) begin
				irqEn_ff <= 1'b0;
			end
			if (twosOnCmd) begin
				twos_ff <= 1'b1;
			end else if (twosOffCmd) begin
				twos_ff <= 1'b0;
			end
			if (autoOnCmd) begin
				autoMode_ff <= 1'b1;
			end else if (autoOffCmd) begin
				autoMode_ff <= 1'b0;
			end
		end
	end

	// digital io direction; a group write beats a same-cycle reset write, which cannot coincide anyway
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			outLow_ff <= 1'b0;
			outHigh_ff <= 1'b0;
			dioLatch_ff <= 16'h0000;
		end else begin
			if (wrDioRst) begin
				outLow_ff <= 1'b0;
				outHigh_ff <= 1'b0;
			end
			if (wrLow) begin
				outLow_ff <= 1'b1;
				dioLatch_ff[7:0] <= wByte;
			end
			if (wrHigh) begin
				outHigh_ff <= 1'b1;
				dioLatch_ff[15:8] <= wByte;
			end
		end
	end

	// dac word and update strobes
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			dac2_ff <= 16'h0000;
			dac2Load_ff <= 1'b0;
			dac1Upd_ff <= 1'b0;
		end else begin
			if (wrDac2) dac2_ff <= req.wdata[15:0];
			dac2Load_ff <= wrDac2;
			// in simultaneous mode the first dac write commits both outputs
			dac1Upd_ff <= wrDac1 & ~autoMode_ff;
		end
	end

	// fifo driven interrupt and conversion pause
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			irq_ff <= 1'b0;
			pause_ff <= 1'b0;
		end else begin
			irq_ff <= irqEn_ff & fifoHalfFull;
			pause_ff <= fifoFull;
		end
	end

	// counter-timer window passes byte accesses through
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tWr_ff <= 1'b0;
			tRd_ff <= 1'b0;
			tSel_ff <= 2'b00;
			tData_ff <= 8'h00;
		end else begin
			tWr_ff <= req.wrStb & inTimer;
			tRd_ff <= req.rdStb & inTimer;
			if (req.wrStb | req.rdStb) tSel_ff <= req.idx[1:0];
			if (req.wrStb) tData_ff <= wByte;
		end
	end

	// loader next state: two address bits, eight value bits, then the end write
	always_comb begin
		nxt_calState = calState_ff;
		nxt_calCount = calCount_ff;
		nxt_calSel = calSel_ff;
		nxt_calShift = calShift_ff;
		calCommit = 1'b0;
		// writes with the serial clock bit low are ignored, so a stray byte cannot shift
		if (calStep) begin
			nxt_calCount = calCount_ff + 4'd1;
			case (calState_ff)
				CAL_ADDR: begin
					nxt_calSel = {calSel_ff[0], calBit};
					if (calCount_ff == 4'd1) begin
						nxt_calState = CAL_DATA;
					end
				end
				CAL_DATA: begin
					nxt_calShift = {calShift_ff[6:0], calBit};
					if (calCount_ff == CAL_WRITES - 4'd2) begin
						nxt_calState = CAL_END;
					end
				end
				CAL_END: begin
					// the terminating write commits; its serial bit carries nothing
					calCommit = 1'b1;
					nxt_calState = CAL_ADDR;
					nxt_calCount = 4'd0;
				end
				default: begin
					nxt_calState = CAL_ADDR;
					nxt_calCount = 4'd0;
				end
			endcase
		end
	end

	// loader registers; pots restart at mid-scale
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			calState_ff <= CAL_ADDR;
			calCount_ff <= 4'd0;
			calSel_ff <= 2'b00;
			calShift_ff <= 8'h00;
			for (int i = 0; i < 4; i++) begin
				calPot_ff[i] <= CAL_RESET_VALUE;
			end
		end else begin
			calState_ff <= nxt_calState;
			calCount_ff <= nxt_calCount;
			calSel_ff <= nxt_calSel;
			calShift_ff <= nxt_calShift;
			if (calCommit) begin
				calPot_ff[calSel_ff] <= calShift_ff;
			end
		end
	end

	// a taken read needs one wait state, since its data comes from a registered mux
	wire readTake = hsel & hready & htrans[1] & ~hwrite;
	// read data captured one cycle after the data phase begins; hready held low for it
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata_ff <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp_ff <= 1'b0;
		end else begin
			hreadyout <= ~readTake;
			// no error case exists; the flop only keeps every output registered
			hresp_ff <= 1'b0;
			if (req.rdStb) rdata_ff <= {24'h000000, rdSel};
		end
	end

	assign hrdata = rdata_ff;
	assign hresp = hresp_ff;
	assign convPause = pause_ff;
	assign twosComplement = twos_ff;
	assign irqReq = irq_ff;
	assign secondDacWord = dac2_ff;
	assign secondDacLoad = dac2Load_ff;
	assign firstDacUpdate = dac1Upd_ff;
	assign dacAutoMode = autoMode_ff;
	assign timerWrStb = tWr_ff;
	assign timerRdStb = tRd_ff;
	assign timerSel = tSel_ff;
	assign timerWdata = tData_ff;
	assign calPot0 = calPot_ff[0];
	assign calPot1 = calPot_ff[1];
	assign calPot2 = calPot_ff[2];
	assign calPot3 = calPot_ff[3];
	assign dioOut = dioLatch_ff;
	assign dioOe = {{8{outHigh_ff}}, {8{outLow_ff}}};
endmodule // daq_board_control_registers

// ### src/daq_ctrl_pkg.sv
// constants shared by the board control register bank
// assumes a 32-bit ahb-lite fabric; printed offsets are register indices
package daq_ctrl_pkg;
	// register indices as printed; byte address is four times the index
	localparam logic [5:0] IDX_CHANNEL_READBACK = 6'h0a;
	localparam logic [5:0] IDX_CAL_SERIAL = 6'h0b;
	localparam logic [5:0] IDX_IRQ_ENABLE = 6'h0c;
	localparam logic [5:0] IDX_FORMAT_SELECT = 6'h0d;
	localparam logic [5:0] IDX_SECOND_DAC = 6'h0e;
	localparam logic [5:0] IDX_DIO_LOW = 6'h10;
	localparam logic [5:0] IDX_DIO_HIGH = 6'h11;
	localparam logic [5:0] IDX_TIMER_FIRST = 6'h14;
	localparam logic [5:0] IDX_TIMER_LAST = 6'h17;
	localparam logic [5:0] IDX_DAC_MODE = 6'h18;
	localparam logic [5:0] IDX_DIO_RESET = 6'h19;
	localparam logic [5:0] IDX_FIRST_DAC = 6'h08;
	localparam logic [5:0] IDX_CAL_VALUE = 6'h20;
	// command values
	localparam logic [7:0] IRQ_ON_VALUE = 8'h10;
	localparam logic [7:0] IRQ_OFF_VALUE = 8'h00;
	localparam logic [7:0] MODE_ONE_VALUE = 8'h01;
	localparam logic [7:0] MODE_ZERO_VALUE = 8'h00;
	// serial calibration field positions
	localparam int CAL_DATA_BIT = 7;
	localparam int CAL_CLOCK_BIT = 0;
	localparam logic [3:0] CAL_WRITES = 4'd11;
	localparam logic [7:0] CAL_RESET_VALUE = 8'h80;
	localparam logic [3:0] CHANNEL_RESET = 4'h0;
	typedef enum logic [1:0] {
		CAL_ADDR = 2'b00,
		CAL_DATA = 2'b01,
		CAL_END = 2'b10
	} cal_state_t;
endpackage
